// *** icm_pkg.sv ***
package icm_pkg;
    // register word indices; byte address is four times the index
    localparam logic [1:0] IDX_DATA = 2'h0;
    localparam logic [1:0] IDX_CTRL = 2'h1;
    localparam logic [1:0] IDX_ISTAT = 2'h2;
    localparam logic [1:0] IDX_IMASK = 2'h3;
    // control write bit positions
    localparam int CB_ES0 = 6;
    localparam int CB_ENI = 3;
    localparam int CB_STA = 2;
    localparam int CB_STO = 1;
    localparam int CB_ACK = 0;
    // status read bit positions
    localparam int SB_PIN = 7;
    localparam int SB_LRB = 3;
    localparam int SB_INIT = 2;
    localparam int SB_FREE = 0;
    // interrupt status bit positions
    localparam int IB_BYTE = 0;
    localparam int IB_STOP = 1;
    // register pointer codes, ordered {es0, es1, es2}
    localparam logic [2:0] PTR_OWN = 3'h0;
    localparam logic [2:0] PTR_CLK = 3'h2;
    // values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CLK_SEL_RST = 8'h00;
    localparam logic [1:0] IMASK_RST = 2'h0;
    // timing: system clock period and serial rates per clock select code
    localparam int CLK_PERIOD_NS = 4;
    localparam int SCL_KHZ_0 = 100;
    localparam int SCL_KHZ_1 = 50;
    localparam int SCL_KHZ_2 = 25;
    localparam int SCL_KHZ_3 = 400;

    typedef enum logic [1:0] {
        OP_START = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ = 2'b10,
        OP_STOP = 2'b11
    } icm_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_BIT = 2'b10,
        ST_STOP = 2'b11
    } icm_state_t;

    // command from register side to the serial engine
    typedef struct packed {
        logic go;
        icm_op_t op;
        logic [7:0] data;
        logic ack_en;
    } icm_cmd_t;

    // result from the serial engine
    typedef struct packed {
        logic done;
        logic was_stop;
        logic [7:0] rx_data;
        logic rx_ack;
        logic bus_busy;
        logic idle;
    } icm_res_t;

    // quarter serial period in system clocks, rounded down
    function automatic logic [11:0] quarter_count(input logic [1:0] sel);
        int khz;
        unique case (sel)
            2'h0: khz = SCL_KHZ_0;
            2'h1: khz = SCL_KHZ_1;
            2'h2: khz = SCL_KHZ_2;
            default: khz = SCL_KHZ_3;
        endcase
        quarter_count = 12'(1000000 / (khz * 4 * CLK_PERIOD_NS));
    endfunction

    // pointer 1x0 reaches the bus data register
    function automatic logic is_data_ptr(input logic [2:0] ptr);
        is_data_ptr = ptr[2] && !ptr[0];
    endfunction
endpackage

// *** icm_byte_engine.sv ***
`timescale 1ns/1ns
module icm_byte_engine (
    input wire logic clk_sys,
    input wire logic rst,
    input wire icm_pkg::icm_cmd_t cmd,
    input wire logic [1:0] rate_sel,
    output icm_pkg::icm_res_t res,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import icm_pkg::*;

    icm_state_t state_reg;
    logic [1:0] ph_reg; // quarter phase inside a bit
    logic [3:0] cnt_reg; // bit index, 8 is the ack slot
    logic [11:0] qcnt_reg;
    logic [7:0] shift_reg; // tx bits out, rx bits in
    logic rd_reg, ack_en_reg, rx_ack_reg, done_reg, was_stop_reg, busy_reg;
    logic scl_m_reg, scl_s_reg, scl_d_reg, sda_m_reg, sda_s_reg, sda_d_reg;
    logic stall, tick;

    // open drain: low is driven, high is released
    always_ff @(posedge clk_sys) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    // two-flop synchronisers, then a delayed copy for edges
    always_ff @(posedge clk_sys) begin
        scl_m_reg <= scl_i;
        scl_s_reg <= scl_m_reg;
        scl_d_reg <= scl_s_reg;
        sda_m_reg <= sda_i;
        sda_s_reg <= sda_m_reg;
        sda_d_reg <= sda_s_reg;
    end

    // bus busy from start/stop seen on the wires
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else if (scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg) begin
            busy_reg <= 1'b1;
        end else if (scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg) begin
            busy_reg <= 1'b0;
        end
    end

    // a slave holding scl low freezes the quarter timer
    assign stall = !scl_oe && !scl_s_reg && state_reg != ST_IDLE;
    assign tick = qcnt_reg == 12'h000 && !stall;

    // quarter period timer
    always_ff @(posedge clk_sys) begin
        if (rst || state_reg == ST_IDLE || tick) begin
            qcnt_reg <= quarter_count(rate_sel);
        end else if (!stall) begin
            qcnt_reg <= qcnt_reg - 12'h001;
        end
    end

    // bit sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            ph_reg <= 2'h0;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            rd_reg <= 1'b0;
            ack_en_reg <= 1'b0;
            rx_ack_reg <= 1'b0;
            done_reg <= 1'b0;
            was_stop_reg <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    ph_reg <= 2'h0;
                    cnt_reg <= 4'h0;
                    if (cmd.go) begin
                        was_stop_reg <= cmd.op == OP_STOP;
                        rd_reg <= cmd.op == OP_READ;
                        ack_en_reg <= cmd.ack_en;
                        shift_reg <= cmd.data;
                        unique case (cmd.op)
                            OP_START: state_reg <= ST_START;
                            OP_WRITE, OP_READ: state_reg <= ST_BIT;
                            OP_STOP: state_reg <= ST_STOP;
                        endcase
                    end
                end
                ST_START: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    unique case (ph_reg)
                        2'h0: sda_oe <= 1'b0; // also serves a repeated start
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b1; // falling sda while scl high
                        2'h3: begin
                            scl_oe <= 1'b1;
                            state_reg <= ST_BIT; // address byte follows
                        end
                    endcase
                end
                ST_BIT: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    unique case (ph_reg)
                        2'h0: begin
                            if (cnt_reg == 4'h9) begin
                                sda_oe <= 1'b0;
                                done_reg <= 1'b1;
                                state_reg <= ST_IDLE;
                            end else if (rd_reg) begin
                                sda_oe <= cnt_reg == 4'h8 && ack_en_reg;
                            end else begin
                                sda_oe <= cnt_reg != 4'h8 && !shift_reg[7];
                            end
                        end
                        2'h1: scl_oe <= 1'b0;
                        2'h2: begin
                            if (cnt_reg == 4'h8) begin
                                rx_ack_reg <= sda_s_reg;
                            end else begin
                                shift_reg <= {shift_reg[6:0], sda_s_reg};
                            end
                        end
                        2'h3: begin
                            scl_oe <= 1'b1; // scl parks low between bytes
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    endcase
                end
                ST_STOP: if (tick) begin
                    ph_reg <= ph_reg + 2'h1;
                    unique case (ph_reg)
                        2'h0: sda_oe <= 1'b1;
                        2'h1: scl_oe <= 1'b0;
                        2'h2: sda_oe <= 1'b0; // rising sda while scl high
                        2'h3: begin
                            done_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

    assign res = '{done: done_reg, was_stop: was_stop_reg, rx_data: shift_reg,
        rx_ack: rx_ack_reg, bus_busy: busy_reg, idle: state_reg == ST_IDLE};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    stop_release_a: assert property (done_reg && was_stop_reg |-> !scl_oe && !sda_oe)
        else $error("lines not released after stop");
    start_shape_a: assert property ($rose(sda_oe) && state_reg == ST_START |-> !scl_oe)
        else $error("start driven with scl low");
endmodule

// *** icm_i2c_ctrl.sv ***
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
// What this block does
// - first data byte is address, lsb direction
// - interrupt after start, address and ack
// - interrupt after every byte on bus
// - own address accessed first; first access recorded
// - cleared ack bit withholds ack last byte
// - data read in receive starts next byte
// - select line high reaches control/status
// - pointer picks data, own address or clock
// - byte done clears pending, enabled interrupt fires
module icm_i2c_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    import icm_pkg::*;

    // bus side state
    logic pend_reg; // data phase in progress
    logic [31:0] paddr_reg;
    logic pwrite_reg;
    // registers reached by software
    logic [7:0] ctrl_reg; // last control write, holds pointer
    logic [7:0] own_addr_reg;
    logic [7:0] clk_sel_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [1:0] istat_reg;
    logic [1:0] imask_reg;
    // block state
    logic pin_reg; // high while no byte is pending service
    logic lrb_reg; // last ack bit seen on the wire
    logic dir_rx_reg; // transfer direction from address lsb
    logic active_reg; // between start and stop
    logic first_done_reg, init_ok_reg;
    icm_cmd_t cmd_reg;
    icm_res_t res;
    // decoded data phase
    logic addr_ok, wr_ev, rd_ev, data_ptr;
    logic [1:0] idx;
    logic [2:0] ptr;
    logic [7:0] wdat, status_vec, rd_val;
    logic [1:0] ist_set, ist_clr;
    logic accept;

    assign accept = hsel && htrans[1] && hready;
    assign idx = paddr_reg[3:2];
    assign addr_ok = paddr_reg[31:4] == 28'h0000000;
    assign wr_ev = pend_reg && pwrite_reg && addr_ok;
    assign rd_ev = pend_reg && !pwrite_reg && addr_ok;
    assign wdat = hwdata[7:0];
    assign ptr = ctrl_reg[CB_ES0 -: 3];
    assign data_ptr = is_data_ptr(ptr);

    // ahb-lite slave: one wait state so read data comes from a flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_reg <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
            paddr_reg <= 32'h00000000;
            pwrite_reg <= 1'b0;
        end else if (pend_reg) begin
            pend_reg <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= pwrite_reg ? 32'h00000000 : {24'h000000, rd_val};
        end else if (accept) begin
            pend_reg <= 1'b1;
            hreadyout <= 1'b0;
            paddr_reg <= haddr;
            pwrite_reg <= hwrite;
        end
    end

    // status byte as software sees it
    always_comb begin
        status_vec = 8'h00;
        status_vec[SB_PIN] = pin_reg;
        status_vec[SB_LRB] = lrb_reg;
        status_vec[SB_INIT] = init_ok_reg;
        status_vec[SB_FREE] = !res.bus_busy;
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_val = 8'h00;
        if (addr_ok) begin
            unique case (idx)
                IDX_DATA: begin
                    if (data_ptr) begin
                        rd_val = rx_reg;
                    end else if (ptr == PTR_OWN) begin
                        rd_val = own_addr_reg;
                    end else if (ptr == PTR_CLK) begin
                        rd_val = clk_sel_reg;
                    end
                end
                IDX_CTRL: rd_val = status_vec;
                IDX_ISTAT: rd_val = {6'h00, istat_reg};
                IDX_IMASK: rd_val = {6'h00, imask_reg};
            endcase
        end
    end

    // register writes from the data phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            own_addr_reg <= 8'h00;
            clk_sel_reg <= CLK_SEL_RST;
            tx_reg <= 8'h00;
            imask_reg <= IMASK_RST;
        end else if (wr_ev) begin
            unique case (idx)
                IDX_CTRL: ctrl_reg <= wdat;
                IDX_DATA: begin
                    if (data_ptr) begin
                        tx_reg <= wdat;
                    end else if (ptr == PTR_OWN) begin
                        own_addr_reg <= wdat;
                    end else if (ptr == PTR_CLK) begin
                        clk_sel_reg <= wdat;
                    end
                end
                IDX_IMASK: imask_reg <= wdat[1:0];
                IDX_ISTAT: ;
            endcase
        end
    end

    // first data-side access after reset tells whether init order held
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            first_done_reg <= 1'b0;
            init_ok_reg <= 1'b0;
        end else if ((wr_ev || rd_ev) && idx == IDX_DATA && !first_done_reg) begin
            first_done_reg <= 1'b1;
            init_ok_reg <= pwrite_reg && ptr == PTR_OWN;
        end
    end

    // commands to the serial engine; ignored while it is busy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_reg <= '{go: 1'b0, op: OP_START, data: 8'h00, ack_en: 1'b0};
            dir_rx_reg <= 1'b0;
            active_reg <= 1'b0;
        end else begin
            cmd_reg.go <= 1'b0;
            if (wr_ev && idx == IDX_CTRL && res.idle && wdat[CB_STA]) begin
                cmd_reg <= '{go: 1'b1, op: OP_START, data: tx_reg, ack_en: 1'b0};
                dir_rx_reg <= tx_reg[0];
                active_reg <= 1'b1;
            end else if (wr_ev && idx == IDX_CTRL && res.idle && wdat[CB_STO]) begin
                cmd_reg <= '{go: 1'b1, op: OP_STOP, data: 8'h00, ack_en: 1'b0};
                active_reg <= 1'b0;
            end else if (wr_ev && idx == IDX_DATA && data_ptr && active_reg && !dir_rx_reg
                    && res.idle) begin
                cmd_reg <= '{go: 1'b1, op: OP_WRITE, data: wdat, ack_en: 1'b0};
            end else if (rd_ev && idx == IDX_DATA && data_ptr && active_reg && dir_rx_reg
                    && res.idle) begin
                // reading the byte starts clocking of the next one
                cmd_reg <= '{go: 1'b1, op: OP_READ, data: 8'h00,
                    ack_en: ctrl_reg[CB_ACK]};
            end
        end
    end

    // pending flag, received byte and ack bit
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_reg <= 1'b1;
            rx_reg <= 8'h00;
            lrb_reg <= 1'b0;
        end else if (res.done && !res.was_stop) begin
            pin_reg <= 1'b0;
            rx_reg <= res.rx_data;
            lrb_reg <= res.rx_ack;
        end else if (cmd_reg.go) begin
            pin_reg <= 1'b1;
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    assign ist_set = {res.done && res.was_stop, res.done && !res.was_stop && ctrl_reg[CB_ENI]};
    assign ist_clr = (wr_ev && idx == IDX_ISTAT) ? wdat[1:0] : 2'h0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            istat_reg <= 2'h0;
            irq <= 1'b0;
        end else begin
            istat_reg <= (istat_reg & ~ist_clr) | ist_set;
            irq <= |(istat_reg & imask_reg);
        end
    end

    icm_byte_engine u_engine (
        .clk_sys(clk_sys),
        .rst(rst),
        .cmd(cmd_reg),
        .rate_sel(clk_sel_reg[1:0]),
        .res(res),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe(scl_oe),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe(sda_oe)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    wait_state_a: assert property (accept && !pend_reg |=> !hreadyout ##1 hreadyout)
        else $error("bus answer timing wrong");
    ctrl_route_a: assert property (rd_ev && idx == IDX_CTRL |=> hrdata[7:0] == $past(status_vec))
        else $error("control read not routed to status");
    ptr_clk_a: assert property (rd_ev && idx == IDX_DATA && ptr == PTR_CLK
        |=> hrdata[7:0] == $past(clk_sel_reg))
        else $error("pointer did not select clock register");
    addr_dir_a: assert property (wr_ev && idx == IDX_CTRL && res.idle && wdat[CB_STA]
        |=> cmd_reg.go && cmd_reg.op == OP_START && dir_rx_reg == $past(tx_reg[0]))
        else $error("start not issued with address direction");
    rx_trigger_a: assert property (rd_ev && idx == IDX_DATA && data_ptr && active_reg
        && dir_rx_reg && res.idle |=> cmd_reg.go && cmd_reg.op == OP_READ)
        else $error("data read did not start reception");
    last_nack_a: assert property (cmd_reg.go && cmd_reg.op == OP_READ
        |-> cmd_reg.ack_en == $past(ctrl_reg[CB_ACK]))
        else $error("ack enable not taken from control");
    byte_pin_a: assert property (res.done && !res.was_stop |=> !pin_reg)
        else $error("pending not cleared on byte end");
    eni_irq_a: assert property (res.done && !res.was_stop && ctrl_reg[CB_ENI] && imask_reg[IB_BYTE]
        |=> istat_reg[IB_BYTE] ##1 irq)
        else $error("byte interrupt missing");
    stop_free_a: assert property (res.done && res.was_stop |-> !active_reg)
        else $error("transfer still active after stop");
    first_own_a: assert property (wr_ev && idx == IDX_DATA && !first_done_reg && ptr == PTR_OWN
        |=> init_ok_reg && first_done_reg)
        else $error("first own address access not recorded");

    start_c: cover property (cmd_reg.go && cmd_reg.op == OP_START);
    read_c: cover property (cmd_reg.go && cmd_reg.op == OP_READ && !cmd_reg.ack_en);
    stop_c: cover property (res.done && res.was_stop);
    irq_c: cover property (irq);
endmodule

// *** icm_slave_model.sv ***
`timescale 1ns/1ns
// behavioural serial slave: acks its address, keeps the last byte written,
// returns a counting pattern when read; never stretches the clock
module icm_slave_model #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull
);
    logic [7:0] sh = 8'h00; // incoming shift
    logic [7:0] tx = 8'ha5; // next byte to return
    logic [7:0] got = 8'h00; // last byte written to us
    logic adr = 1'b0; // next byte is the address
    logic act = 1'b0; // addressed
    logic rd = 1'b0; // read direction
    logic mack = 1'b0; // ninth bit seen low
    int n = 0; // bits seen in this byte
    initial sda_pull = 1'b0;
    // start: data falls while clock high
    always @(negedge sda) if (scl === 1'b1) begin
        n = 0;
        adr = 1'b1;
        act = 1'b0;
    end
    // stop: let go of the line
    always @(posedge sda) if (scl === 1'b1) begin
        act = 1'b0;
        sda_pull = 1'b0;
    end
    // sample on rising clock; the ninth bit is the acknowledge
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        else mack = (sda === 1'b0);
        n = n + 1;
    end
    // only change data while the clock is low, so no false start or stop
    always @(negedge scl) begin
        if (n == 8) begin
            if (adr) begin
                act = (sh[7:1] == ADDR);
                rd = sh[0];
            end else if (rd) tx = tx + 8'h11;
            else if (act) got = sh;
            sda_pull = act && (adr || !rd);
            adr = 1'b0;
        end else if (n == 9) begin
            n = 0;
            // a withheld ack ends our sending: the line floats high
            sda_pull = act && rd && mack && !tx[7];
        end else sda_pull = act && rd && mack && !tx[7 - n];
    end
endmodule

// *** icm_i2c_ctrl_bench.sv ***
`timescale 1ns/1ns
module icm_i2c_ctrl_bench;
    import icm_pkg::*;
    localparam logic [6:0] SADR = 7'h2a; // slave address used
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, irq, sda_pull;
    wire scl_w = ~scl_oe; // open drain with pull-up
    wire sda_w = ~(sda_oe | sda_pull);
    int err_total = 0;
    int n_checks = 0;
    always #2 clk_sys = ~clk_sys;
    icm_i2c_ctrl i_icm_i2c_ctrl (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    icm_slave_model #(.ADDR(SADR)) i_icm_slave_model (.scl(scl_w), .sda(sda_w),
        .sda_pull(sda_pull));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [31:0] ad(input logic [1:0] i);
        return {28'h0, i, 2'h0};
    endfunction
    // one single word transfer; read data lands in q
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    // bounded wait for the interrupt line
    task automatic wirq(input string nm);
        int k;
        k = 0;
        while (irq !== 1'b1 && k < 9000) begin
            @(posedge clk_sys);
            k++;
        end
        chk(nm, {31'h0, irq}, 32'h1);
    endtask
    // poll status until the bus reads free
    task automatic wfree;
        int k;
        k = 0;
        q = 32'h0;
        while (q[SB_FREE] !== 1'b1 && k < 3000) begin
            bus(1'b0, ad(IDX_CTRL), 32'h0);
            k++;
        end
        chk("bus free", {31'h0, q[SB_FREE]}, 32'h1);
    endtask
    // mask off, on, then clear: the line follows status and mask
    task automatic irqc(input logic [1:0] m, input logic [1:0] s, input logic e);
        bus(1'b1, ad(IDX_IMASK), {30'h0, m});
        if (s != 2'h0) bus(1'b1, ad(IDX_ISTAT), {30'h0, s});
        repeat (2) @(posedge clk_sys);
        chk("irq level", {31'h0, irq}, {31'h0, e});
    endtask
    task automatic tend(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, well past the expected serial traffic
    initial begin
        #360000;
        err_total++;
        conclude;
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        // values after reset; status is on the high select line
        rdc(ad(IDX_CTRL), 32'h81, "status");
        rdc(ad(IDX_ISTAT), 32'h0, "istat");
        rdc(ad(IDX_IMASK), 32'h0, "imask");
        rdc(32'h10, 32'h0, "unmapped");
        chk("unmapped okay", {31'h0, hresp}, 32'h0);
        tend("reset");
        // own address first, then clock select, each by pointer then data
        bus(1'b1, ad(IDX_CTRL), 32'h00);
        bus(1'b1, ad(IDX_DATA), 32'h55);
        rdc(ad(IDX_CTRL), 32'h85, "first access flag");
        bus(1'b1, ad(IDX_CTRL), 32'h20);
        bus(1'b1, ad(IDX_DATA), 32'h03);
        rdc(ad(IDX_DATA), 32'h03, "clock select");
        bus(1'b1, ad(IDX_CTRL), 32'h00);
        rdc(ad(IDX_DATA), 32'h55, "own address");
        tend("init");
        // write one byte; pointer 110 also reaches the data register
        bus(1'b1, ad(IDX_IMASK), 32'h3);
        bus(1'b1, ad(IDX_CTRL), 32'h60);
        wfree;
        bus(1'b1, ad(IDX_DATA), {24'h0, SADR, 1'b0});
        bus(1'b1, ad(IDX_CTRL), 32'h4d);
        wirq("address irq");
        rdc(ad(IDX_CTRL), 32'h04, "pending and acked");
        rdc(ad(IDX_ISTAT), 32'h1, "byte done");
        irqc(2'h3, 2'h1, 1'b0);
        bus(1'b1, ad(IDX_DATA), 32'h3c);
        wirq("data irq");
        chk("slave byte", {24'h0, i_icm_slave_model.got}, 32'h3c);
        bus(1'b1, ad(IDX_ISTAT), 32'h1);
        bus(1'b1, ad(IDX_CTRL), 32'hc3);
        wirq("stop irq");
        wfree;
        chk("lines released", {30'h0, scl_oe, sda_oe}, 32'h0);
        chk("drive levels", {30'h0, scl_o, sda_o}, 32'h0);
        irqc(2'h1, 2'h0, 1'b0);
        irqc(2'h3, 2'h0, 1'b1);
        irqc(2'h3, 2'h2, 1'b0);
        tend("transmit");
        // read two bytes; first data read only starts the first byte
        bus(1'b1, ad(IDX_CTRL), 32'h40);
        wfree;
        bus(1'b1, ad(IDX_DATA), {24'h0, SADR, 1'b1});
        bus(1'b1, ad(IDX_CTRL), 32'h4d);
        wirq("read address irq");
        bus(1'b1, ad(IDX_ISTAT), 32'h1);
        bus(1'b0, ad(IDX_DATA), 32'h0);
        wirq("first byte irq");
        bus(1'b1, ad(IDX_ISTAT), 32'h1);
        bus(1'b1, ad(IDX_CTRL), 32'h48);
        rdc(ad(IDX_DATA), 32'ha5, "first byte");
        wirq("last byte irq");
        chk("ack withheld", {31'h0, i_icm_slave_model.mack}, 32'h0);
        bus(1'b1, ad(IDX_ISTAT), 32'h1);
        bus(1'b1, ad(IDX_CTRL), 32'hc3);
        wfree;
        tend("receive");
        conclude;
    end
endmodule
